// file: design/lpd_pkg.sv
// Package: constants and carriers for the low-power DDR data lane
package lpd_pkg;

	localparam int LANE_W      = 8;
	localparam int NUM_LANES   = 4;
	localparam int DQ_W        = LANE_W * NUM_LANES;
	localparam int X16_LANES   = 2;
	localparam int BA_W        = 2;
	localparam int ROW_W       = 13;
	localparam int COL_W       = 10;
	localparam int COL_W_X32   = 9;
	localparam int CA_W        = 16;
	localparam int BURST_LEN   = 4;
	localparam int BEAT_W      = 2;
	localparam int CNT_W       = 4;
	localparam logic [CNT_W-1:0] WRITE_LAT = 4'h2;
	localparam logic [CNT_W-1:0] READ_LAT  = 4'h3;

	// First half of a command: op bits, bank, upper row bits
	localparam int H0_WR_BIT   = 15;
	localparam int H0_RD_BIT   = 14;
	localparam int H0_BA_LSB   = 12;
	localparam int H0_ROW_LSB  = 0;
	// Second half: lowest row bit, column bits 9..1
	localparam int H1_ROW0_BIT = 15;
	localparam int H1_COL_LSB  = 0;

	localparam logic [1:0] SETTLE_DONE = 2'h3;

	typedef struct packed {
		logic [BA_W-1:0]  bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
	} lpd_addr_s;

	typedef enum logic [3:0] {
		LPD_IDLE  = 4'h1,
		LPD_CMD2  = 4'h2,
		LPD_WAIT  = 4'h4,
		LPD_BURST = 4'h8
	} lpd_state_e;

	typedef struct packed {
		logic              run;
		logic [1:0]        settle;
		logic              strap_s1;
		logic              strap_s2;
		logic              width_x32;
		logic              wtog_s1;
		logic              wtog_s2;
		logic              wtog_seen;
		logic [7:0]        bursts;
	} lpd_core_s;

	typedef struct packed {
		logic              rst_s1;
		logic              rst_s2;
		logic              wid_s1;
		logic              wid_s2;
		logic              phase;
		lpd_state_e        state;
		logic [CA_W-1:0]   half0;
		logic              is_wr;
		lpd_addr_s         addr;
		logic [CNT_W-1:0]  cnt;
		logic [BEAT_W-1:0] beat;
		logic              wr_tog;
		logic [DQ_W-1:0]   dq_out;
		logic              dq_oe;
		logic              strobe;
		logic              strobe_c;
		logic              strobe_oe;
	} lpd_link_s;

endpackage

// file: design/lpd_addr_map.sv
// Command/address decode: two bus halves into bank, row and column
`timescale 1ns/100ps
module lpd_addr_map
	import lpd_pkg::*;
(
	input  wire logic [CA_W-1:0] half0,
	input  wire logic [CA_W-1:0] half1,
	input  wire logic            width_x32,
	output lpd_addr_s            addr,
	output logic                 op_wr,
	output logic                 op_rd
);

	logic [COL_W-1:0] col_raw;

	assign op_wr     = half0[H0_WR_BIT];
	assign op_rd     = half0[H0_RD_BIT];
	assign addr.bank = half0[H0_BA_LSB +: BA_W];
	assign addr.row  = {half0[H0_ROW_LSB +: ROW_W-1], half1[H1_ROW0_BIT]};
	// Column bit zero never travels on the bus
	assign col_raw   = {half1[H1_COL_LSB +: COL_W-1], 1'b0};
	// On x32 the top column position is a don't-care
	assign addr.col  = width_x32 ? {1'b0, col_raw[COL_W_X32-1:0]} : col_raw;

endmodule

// file: design/lpd_data_lane.sv
// Data lane of a low-power DDR device: strobes, write masking, storage
`timescale 1ns/100ps
module lpd_data_lane
	import lpd_pkg::*;
#(
	parameter int STORE_AW = 6
)
(
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              width_x32_pin,
	input  wire logic              link_clk,
	input  wire logic              cs_n,
	input  wire logic [CA_W-1:0]   cmd_addr_bus,
	input  wire logic [DQ_W-1:0]   dq_in,
	input  wire logic [NUM_LANES-1:0] write_mask,
	output logic [DQ_W-1:0]        dq_out,
	output logic                   dq_oe,
	output logic                   strobe_t_out,
	output logic                   strobe_c_out,
	output logic                   strobe_oe,
	output logic                   width_x32,
	output logic [7:0]             bursts_written
);

	lpd_core_s core_ff;
	lpd_core_s nxt_core;
	lpd_link_s link_ff;
	lpd_link_s nxt_link;

	logic [DQ_W-1:0] mem [2**STORE_AW];

	lpd_addr_s dec_addr;
	logic      dec_wr;
	logic      dec_rd;

	logic [STORE_AW-1:0] beat_idx;
	logic                lane_we [NUM_LANES];

	// Burst walks sequentially within its aligned group of four columns
	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] col,
						      input logic [BEAT_W-1:0] beat);
		burst_col = {col[COL_W-1:BEAT_W], col[BEAT_W-1:0] + beat};
	endfunction

	// Small store: only the low six column bits form the index; bank and rows alias
	function automatic logic [STORE_AW-1:0] store_index(input lpd_addr_s a,
							   input logic [BEAT_W-1:0] beat);
		logic [BA_W+COL_W-1:0] full;
		full = {a.bank, burst_col(a.col, beat)};
		store_index = full[STORE_AW-1:0];
	endfunction

	lpd_addr_map u_addr_map (
		.half0     (link_ff.half0),
		.half1     (cmd_addr_bus),
		.width_x32 (link_ff.wid_s2),
		.addr      (dec_addr),
		.op_wr     (dec_wr),
		.op_rd     (dec_rd)
	);

	// Core domain: strap capture after reset release, burst counting
	always_comb begin
		nxt_core = core_ff;
		nxt_core.run = 1'b1;
		nxt_core.strap_s1 = width_x32_pin;
		nxt_core.strap_s2 = core_ff.strap_s1;
		// Strap is taken once the synchroniser has settled, then held
		if (core_ff.settle != SETTLE_DONE) begin
			nxt_core.settle = core_ff.settle + 2'h1;
			nxt_core.width_x32 = core_ff.strap_s2;
		end
		nxt_core.wtog_s1 = link_ff.wr_tog;
		nxt_core.wtog_s2 = core_ff.wtog_s1;
		nxt_core.wtog_seen = core_ff.wtog_s2;
		if (core_ff.wtog_s2 != core_ff.wtog_seen) begin
			nxt_core.bursts = core_ff.bursts + 8'h01;
		end
		if (!reset_n) begin
			nxt_core = '0;
		end
	end

	always_ff @(posedge clock) begin
		core_ff <= nxt_core;
	end

	assign beat_idx = store_index(link_ff.addr, link_ff.beat);

	// Each rising link edge is one strobe transition, i.e. one data beat
	always_comb begin
		nxt_link = link_ff;
		nxt_link.rst_s1 = core_ff.run;
		nxt_link.rst_s2 = link_ff.rst_s1;
		nxt_link.wid_s1 = core_ff.width_x32;
		nxt_link.wid_s2 = link_ff.wid_s1;
		nxt_link.phase = ~link_ff.phase;
		nxt_link.dq_oe = 1'b0;
		nxt_link.strobe = 1'b0;
		nxt_link.strobe_c = 1'b0;
		nxt_link.strobe_oe = 1'b0;
		unique case (link_ff.state)
			LPD_IDLE: begin
				// Chip select counts only on the rising half of the clock
				if (!link_ff.phase && !cs_n) begin
					nxt_link.half0 = cmd_addr_bus;
					nxt_link.state = LPD_CMD2;
				end
			end
			LPD_CMD2: begin
				nxt_link.addr = dec_addr;
				nxt_link.is_wr = dec_wr;
				nxt_link.beat = '0;
				if (dec_wr) begin
					nxt_link.cnt = WRITE_LAT;
					nxt_link.state = LPD_WAIT;
				end else if (dec_rd) begin
					nxt_link.cnt = READ_LAT;
					nxt_link.state = LPD_WAIT;
				end else begin
					nxt_link.state = LPD_IDLE;
				end
			end
			LPD_WAIT: begin
				nxt_link.cnt = link_ff.cnt - 4'h1;
				if (link_ff.cnt == 4'h1) begin
					nxt_link.state = LPD_BURST;
				end
			end
			LPD_BURST: begin
				if (!link_ff.is_wr) begin
					nxt_link.dq_out = mem[beat_idx];
					nxt_link.dq_oe = 1'b1;
					nxt_link.strobe_oe = 1'b1;
					// Strobe flips with every data change: edge aligned
					nxt_link.strobe = ~link_ff.beat[0];
					// Complement kept in its own flop so the pin never glitches
					nxt_link.strobe_c = link_ff.beat[0];
				end
				nxt_link.beat = link_ff.beat + 2'h1;
				if (link_ff.beat == BEAT_W'(BURST_LEN - 1)) begin
					nxt_link.state = LPD_IDLE;
					nxt_link.wr_tog = link_ff.wr_tog ^ link_ff.is_wr;
				end
			end
			default: begin
				nxt_link.state = LPD_IDLE;
			end
		endcase
		if (!link_ff.rst_s2) begin
			nxt_link = '0;
			nxt_link.rst_s1 = core_ff.run;
			nxt_link.rst_s2 = link_ff.rst_s1;
			nxt_link.state = LPD_IDLE;
		end
	end

	always_ff @(posedge link_clk) begin
		link_ff <= nxt_link;
	end

	// Byte enables: mask per beat, upper lanes only on the wide part
	always_comb begin
		for (int l = 0; l < NUM_LANES; l++) begin
			lane_we[l] = link_ff.rst_s2 && link_ff.is_wr && (link_ff.state == LPD_BURST)
				&& !write_mask[l]
				&& (link_ff.wid_s2 || l < X16_LANES);
		end
	end

	// Write data is sampled on every beat; centring it is the controller's job
	always_ff @(posedge link_clk) begin
		for (int l = 0; l < NUM_LANES; l++) begin
			if (lane_we[l]) begin
				mem[beat_idx][l*LANE_W +: LANE_W] <= dq_in[l*LANE_W +: LANE_W];
			end
		end
	end

	assign dq_out         = link_ff.dq_out;
	assign dq_oe          = link_ff.dq_oe;
	assign strobe_t_out   = link_ff.strobe;
	assign strobe_c_out   = link_ff.strobe_c;
	assign strobe_oe      = link_ff.strobe_oe;
	assign width_x32      = core_ff.width_x32;
	assign bursts_written = core_ff.bursts;

endmodule

// file: verification/lpd_data_lane_checker.sv
// Checker for the strobe, read drive and write counter ports
`timescale 1ns/100ps
module lpd_data_lane_checker (
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic       link_clk,
	input wire logic       cs_n,
	input wire logic       dq_oe,
	input wire logic       strobe_t_out,
	input wire logic       strobe_c_out,
	input wire logic       strobe_oe,
	input wire logic [7:0] bursts_written
);
	property p_pair; @(posedge link_clk) disable iff (!reset_n) strobe_oe == dq_oe;
	endproperty
	a_pair: assert property (p_pair) else $error("oe pair");
	property p_idle; @(posedge link_clk) disable iff (!reset_n)
		!strobe_oe |-> !strobe_t_out && !strobe_c_out;
	endproperty
	a_idle: assert property (p_idle) else $error("idle strobe");
	property p_comp; @(posedge link_clk) disable iff (!reset_n)
		strobe_oe |-> strobe_c_out != strobe_t_out;
	endproperty
	a_comp: assert property (p_comp) else $error("strobe pair");
	property p_tog; @(posedge link_clk) disable iff (!reset_n)
		strobe_oe && $past(strobe_oe) |-> strobe_t_out != $past(strobe_t_out);
	endproperty
	a_tog: assert property (p_tog) else $error("strobe toggle");
	property p_first; @(posedge link_clk) disable iff (!reset_n) $rose(strobe_oe) |-> strobe_t_out;
	endproperty
	a_first: assert property (p_first) else $error("first edge");
	property p_len; @(posedge link_clk) disable iff (!reset_n)
		$rose(strobe_oe) |-> strobe_oe[*4] ##1 !strobe_oe;
	endproperty
	a_len: assert property (p_len) else $error("burst length");
	// Drive only follows a command taken with chip select low
	property p_cause; @(posedge link_clk) disable iff (!reset_n) $rose(dq_oe) |-> !$past(cs_n, 6);
	endproperty
	a_cause: assert property (p_cause) else $error("drive cause");
	property p_cnt; @(posedge clock) disable iff (!reset_n)
		$changed(bursts_written) |-> bursts_written == $past(bursts_written) + 8'h1;
	endproperty
	a_cnt: assert property (p_cnt) else $error("burst count");
endmodule

// file: verification/lpd_ctrl_model.sv
// Controller model: issues one command, drives write beats, gathers read beats
`timescale 1ns/100ps
module lpd_ctrl_model
	import lpd_pkg::*;
(
	input  wire logic                 link_clk,
	output logic                      cs_n,
	output logic [CA_W-1:0]           cmd_addr_bus,
	output logic [DQ_W-1:0]           dq_in,
	output logic [NUM_LANES-1:0]      write_mask,
	input  wire logic [DQ_W-1:0]      dq_out,
	input  wire logic                 dq_oe
);
	// Beat parity is not visible at the pins, so the bench probes it into want
	logic ph = 1'b0;
	logic want = 1'b0;
	always @(posedge link_clk) ph <= ~ph;
	initial begin
		cs_n = 1'b1;
		cmd_addr_bus = '0;
		dq_in = '0;
		write_mask = '0;
	end
	task automatic xfer(input logic wr, input lpd_addr_s a, input logic [127:0] d,
		input logic [15:0] m, output logic [127:0] q, output int n);
		q = '0;
		n = 0;
		@(posedge link_clk);
		#0.5;
		if (ph !== want) begin
			@(posedge link_clk);
			#0.5;
		end
		cs_n = 1'b0;
		cmd_addr_bus = {wr, !wr, a.bank, a.row[12:1]};
		@(posedge link_clk);
		#0.5;
		cs_n = 1'b1;
		cmd_addr_bus = {a.row[0], 6'h3f, a.col[9:1]};
		for (int i = 0; i < 12; i++) begin
			@(posedge link_clk);
			#0.5;
			if (wr && i > 1 && i < 6) begin
				dq_in = d[(i-2)*DQ_W +: DQ_W];
				write_mask = m[(i-2)*4 +: 4];
			end else begin
				// Released lines must not keep a plausible old value
				dq_in = ~dq_in;
				write_mask = ~write_mask;
				cmd_addr_bus = ~cmd_addr_bus;
			end
			if (dq_oe === 1'b1 && n < 4) begin
				q[n*DQ_W +: DQ_W] = dq_out;
				n++;
			end
		end
	endtask
endmodule

// file: verification/ddr_data_lane_strobe_mask_tb.sv
// Bench for the data lane: masking, column wrap, chip select phase, width strap
`timescale 1ns/100ps
module ddr_data_lane_strobe_mask_tb;
	import lpd_pkg::*;
	logic                 clock = 1'b0;
	logic                 link_clk = 1'b0;
	logic                 reset_n = 1'b0;
	logic                 width_x32_pin = 1'b1;
	logic                 cs_n, dq_oe, strobe_t_out, strobe_c_out, strobe_oe, width_x32;
	logic [CA_W-1:0]      cmd_addr_bus;
	logic [DQ_W-1:0]      dq_in, dq_out;
	logic [NUM_LANES-1:0] write_mask;
	logic [7:0]           bursts_written;
	logic [127:0]         q;
	int                   n, bad_count, comparisons, wcount;
	always #12.5 clock = ~clock;
	always #3 link_clk = ~link_clk;
	lpd_data_lane DUT (.clock, .reset_n, .width_x32_pin, .link_clk, .cs_n, .cmd_addr_bus,
		.dq_in, .write_mask, .dq_out, .dq_oe, .strobe_t_out, .strobe_c_out, .strobe_oe,
		.width_x32, .bursts_written);
	lpd_ctrl_model lc (.link_clk, .cs_n, .cmd_addr_bus, .dq_in, .write_mask, .dq_out, .dq_oe);
	task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic xf(input logic w, input logic [9:0] c, input logic [127:0] d,
		input logic [15:0] m);
		lc.xfer(w, '{2'h1, 13'h0a5a + c, c}, d, m, q, n);
		wcount += w;
	endtask
	// Reset with a strap, then find the beat kind on which chip select counts
	task automatic do_reset(input logic x32);
		int na;
		@(posedge clock);
		#0.5;
		width_x32_pin = x32;
		reset_n = 1'b0;
		wcount = 0;
		repeat (10) @(posedge clock);
		#0.5;
		reset_n = 1'b1;
		repeat (12) @(posedge clock);
		#0.5;
		chk("width", x32, width_x32);
		lc.want = 1'b0;
		xf(1'b0, 10'h0, '0, '0);
		na = n;
		lc.want = 1'b1;
		xf(1'b0, 10'h0, '0, '0);
		chk("one phase", 1, (na == 4) ^ (n == 4));
		lc.want = (n == 4);
	endtask
	task automatic t_mask(input logic x32);
		logic [127:0] a, e, k;
		logic [15:0]  m;
		a = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
		m = 16'h5a3c;
		k = x32 ? '1 : {4{32'h0000ffff}};
		xf(1'b1, 10'h8, a, 16'h0);
		xf(1'b1, 10'h8, ~a, m);
		xf(1'b0, 10'h8, '0, '0);
		for (int i = 0; i < 16; i++) e[i*8 +: 8] = m[i] ? a[i*8 +: 8] : ~a[i*8 +: 8];
		chk("masked beats", e & k, q & k);
		repeat (5) @(posedge clock);
		#0.5;
		chk("bursts", wcount, bursts_written);
	endtask
	// Read starting mid-burst wraps inside the aligned four; odd column reads as even
	task automatic t_wrap();
		logic [127:0] c;
		c = 128'h13579bdf_2468ace0_fdb97531_0eca8642;
		xf(1'b1, 10'h10, c, 16'h0);
		xf(1'b0, 10'h12, '0, '0);
		chk("wrap", {c[63:0], c[127:64]}, q);
		xf(1'b0, 10'h13, '0, '0);
		chk("col bit zero", {c[63:0], c[127:64]}, q);
	endtask
	task automatic close_out();
		if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		bad_count = 0;
		comparisons = 0;
		do_reset(1'b1);
		t_mask(1'b1);
		t_wrap();
		do_reset(1'b0);
		t_mask(1'b0);
		close_out();
	end
endmodule
bind lpd_data_lane lpd_data_lane_checker u_chk (.clock, .reset_n, .link_clk, .cs_n, .dq_oe,
	.strobe_t_out, .strobe_c_out, .strobe_oe, .bursts_written);
